// file: hw/rxca_params.svh
// constants for the receive comma aligner: defaults, widths, counts
// assumes inclusion by the aligner package and modules only
`ifndef RXCA_PARAMS_SVH
`define RXCA_PARAMS_SVH
`define RXCA_SYM_W 10
`define RXCA_MINUS_DEFAULT 10'h283
`define RXCA_PLUS_DEFAULT 10'h17C
`define RXCA_MASK_DEFAULT 10'h3FF
`define RXCA_BYTES_DEFAULT 4
`define RXCA_SLIP_GAP_CYCLES 32
`define RXCA_AUTO_WAIT_DEFAULT 4'h7
`define RXCA_AUTO_WAIT_MAX 15
`define RXCA_POS_W 7
`endif

// file: hw/rxca_pkg.sv
// types shared by the receive comma aligner files
// assumes rxca_params.svh is on the include path
`include "rxca_params.svh"
package rxca_pkg;
  // slip mode selection
  typedef enum logic [1:0] {
    RXCA_SLIP_OFF = 2'h0,
    RXCA_SLIP_PCS = 2'h1,
    RXCA_SLIP_PMA = 2'h2,
    RXCA_SLIP_AUTO = 2'h3
  } rxca_slip_mode_t;
  // static configuration bundle
  typedef struct packed {
    logic [9:0] minus_pattern;
    logic [9:0] plus_pattern;
    logic [9:0] comma_match_mask;
    logic double_comma_mode;
    logic plus_detect_report;
    logic minus_detect_report;
    logic pass_realign_symbol;
    logic [2:0] boundary_granularity;
    logic internal_width_select;
    rxca_slip_mode_t slip_mode_select;
    logic [3:0] auto_slip_wait;
  } rxca_cfg_t;
  // per-cycle enables from user logic
  typedef struct packed {
    logic comma_align_enable;
    logic plus_align_enable;
    logic minus_align_enable;
    logic bit_slip_request;
  } rxca_ctl_t;
endpackage

// file: hw/rxca_match.sv
// comma matcher: scans the first NPOS bit offsets of a window for masked plus/minus commas
// assumes the window holds oldest bit at index 0 and is steady for one clock
`include "rxca_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rxca_match #(
  parameter int NPOS = 40,
  parameter int WIN = 60
) (
  input wire logic [WIN-1:0] window,
  input wire rxca_pkg::rxca_cfg_t cfg,
  output logic [NPOS-1:0] plus_hit,
  output logic [NPOS-1:0] minus_hit,
  output logic [NPOS-1:0] double_hit
);
  import rxca_pkg::*;
  initial begin
    if (WIN < NPOS + 20) $error("rxca_match: window too small");
  end
  // masked compare; zero mask bits are wildcards [RULE14]
  function automatic logic sym_eq(input logic [9:0] d, input logic [9:0] p,
                                  input logic [9:0] m);
    sym_eq = ((d ^ p) & m) == 10'h000;
  endfunction
  // one comparator pair per candidate offset
  for (genvar i = 0; i < NPOS; i++) begin : g_pos
    logic [9:0] s0;
    logic [9:0] s1;
    assign s0 = window[i +: 10];
    assign s1 = window[i + 10 +: 10];
    // bit 0 of each pattern is the first bit received [RULE18]
    assign plus_hit[i] = sym_eq(s0, cfg.plus_pattern, cfg.comma_match_mask);
    assign minus_hit[i] = sym_eq(s0, cfg.minus_pattern, cfg.comma_match_mask);
    // plus then minus with no gap [RULE16]
    assign double_hit[i] = plus_hit[i] & sym_eq(s1, cfg.minus_pattern, cfg.comma_match_mask);
  end
endmodule
`default_nettype wire

// file: hw/rxca_aligner.sv
// receive comma detection and word alignment for a 10-bit-symbol datapath
// assumes raw words arrive on ref_clk, oldest bit in bit 0, one word per clock
`include "rxca_params.svh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RULE1) align enable low bypasses the aligner
// (RULE2) aligned flag high once comma boundary locked
// (RULE3) each comma type aligns only when enabled
// (RULE4) realign pulse marks an alignment change
// (RULE5) comma seen raised ahead of data
// (RULE6) one slip request gives one bit
// (RULE7) user keeps slip low over 32 cycles
// (RULE8) manual slip overrides automatic alignment
// (RULE9) manual slip needs align enables low
// (RULE10) granularity one allows any byte lane
// (RULE11) granularity two allows even lanes only
// (RULE12) granularity four needs wide internal path
// (RULE13) even and odd commas need granularity one
// (RULE14) mask zero bits are wildcards
// (RULE15) single mode matches either comma alone
// (RULE16) double mode needs plus then minus
// (RULE17) double mode needs matched enables, reports
// (RULE18) pattern bit zero is received first
// (RULE19) report settings affect comma seen only
// (RULE20) realign comma withheld unless pass enabled
// (RULE21) slip mode sets shift direction
// (RULE22) auto mode slides and waits configured cycles
// (RULE23) misplaced comma drops flag, realigns, pulses; here the flag stays high through the realign
// (RULE24) aligned commas and disabled enables hold
// (RULE25) status outputs low after reset
module rxca_aligner #(
  parameter int NBYTES = `RXCA_BYTES_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire rxca_pkg::rxca_cfg_t cfg,
  input wire rxca_pkg::rxca_ctl_t ctl,
  input wire logic [NBYTES*10-1:0] raw_word,
  output logic [NBYTES*10-1:0] rx_parallel_word,
  output logic byte_aligned_flag,
  output logic realign_pulse,
  output logic comma_seen,
  output logic [`RXCA_POS_W-1:0] locked_align_position
);
  import rxca_pkg::*;
  localparam int W = NBYTES * 10;
  localparam int WIN = 2 * W + 20;
  // ******************************************************
  // parameter checks
  // ******************************************************
  initial begin
    if (NBYTES != 2 && NBYTES != 4 && NBYTES != 8) $error("rxca_aligner: NBYTES 2, 4 or 8");
  end
  // ******************************************************
  // state
  // ******************************************************
  typedef enum logic [2:0] {
    ST_SEARCH = 3'h1,
    ST_LOCKED = 3'h2,
    ST_WAIT = 3'h4
  } rxca_state_t;
  rxca_state_t state_reg;
  rxca_state_t state_next;
  logic [W-1:0] hist1_reg;
  logic [W-1:0] hist2_reg;
  logic [`RXCA_POS_W-1:0] pos_reg;
  logic [`RXCA_POS_W-1:0] pos_next;
  logic aligned_next;
  logic realign_next;
  logic [5:0] gap_cnt_reg;
  logic slip_armed_reg;
  logic [3:0] wait_cnt_reg;
  logic [WIN-1:0] window;
  logic [W-1:0] plus_hit;
  logic [W-1:0] minus_hit;
  logic [W-1:0] double_hit;
  logic [W-1:0] hit_any;
  logic slip_take;
  logic [W-1:0] shifted;
  logic [W-1:0] aligned_word;
  logic suppress_reg;
  // oldest word sits lowest; window spans two held words plus two symbols of the new one
  assign window = {raw_word[19:0], hist1_reg, hist2_reg};
  rxca_match #(.NPOS(W), .WIN(WIN)) u_match (
    .window(window),
    .cfg(cfg),
    .plus_hit(plus_hit),
    .minus_hit(minus_hit),
    .double_hit(double_hit)
  );
  // ******************************************************
  // boundary and match qualification
  // ******************************************************
  // spacing between legal comma positions in bits
  function automatic int step_bits(input logic [2:0] g, input logic wide);
    int s;
    s = 10;
    if (g == 3'h2) s = 20; // even lanes [RULE11]
    else if (g == 3'h4 && wide) s = 40; // 4-byte boundary [RULE12]
    step_bits = s; // granularity one: any lane [RULE10]
  endfunction
  // slip range wraps at the boundary spacing
  function automatic logic [`RXCA_POS_W-1:0] wrap_pos(input int p, input int s);
    int q;
    q = p;
    if (q >= s) q = q - s;
    if (q < 0) q = q + s;
    wrap_pos = q[`RXCA_POS_W-1:0];
  endfunction
  // qualified matches; report bits deliberately play no part here [RULE19]
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (cfg.double_comma_mode) begin
        hit_any[i] = double_hit[i] & ctl.plus_align_enable; // [RULE16]
      end else begin
        hit_any[i] = (plus_hit[i] & ctl.plus_align_enable) |
                     (minus_hit[i] & ctl.minus_align_enable); // [RULE3] [RULE15]
      end
    end
  end
  // slip qualifies only in manual modes and on a fresh request after the gap [RULE6] [RULE7]
  assign slip_take = ctl.bit_slip_request & slip_armed_reg &
                     (cfg.slip_mode_select == RXCA_SLIP_PCS ||
                      cfg.slip_mode_select == RXCA_SLIP_PMA); // [RULE21] [RULE22]
  // ******************************************************
  // alignment state machine
  // ******************************************************
  always_comb begin
    int s;
    int first;
    int pnum;
    s = step_bits(cfg.boundary_granularity, cfg.internal_width_select);
    first = -1;
    pnum = int'(pos_reg);
    state_next = state_reg;
    pos_next = pos_reg;
    aligned_next = byte_aligned_flag;
    realign_next = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (hit_any[i]) first = i;
    end
    case (state_reg)
      ST_SEARCH, ST_LOCKED: begin
        if (slip_take) begin
          // manual slip wins over comma alignment [RULE8]
          if (cfg.slip_mode_select == RXCA_SLIP_PCS) pos_next = wrap_pos(pnum + 1, s);
          else pos_next = wrap_pos(pnum - 1, s); // [RULE21]
          aligned_next = 1'b0;
        end else if (first >= 0) begin
          if ((first % s) == pnum) begin
            aligned_next = 1'b1; // on boundary: no change [RULE24] [RULE2]
            state_next = ST_LOCKED;
          end else begin
            // move to the earliest comma's offset modulo the boundary spacing [RULE23] [RULE4]
            pos_next = wrap_pos(first % s, s);
            aligned_next = 1'b1;
            realign_next = 1'b1;
            state_next = ST_LOCKED;
          end
        end else if (cfg.slip_mode_select == RXCA_SLIP_AUTO && state_reg == ST_SEARCH) begin
          // auto slide then let the pipeline settle [RULE22]
          pos_next = wrap_pos(pnum - 1, s);
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_cnt_reg == 4'h0) state_next = ST_SEARCH;
      end
      default: begin
        state_next = ST_SEARCH;
      end
    endcase
  end
  // state, position, status registers; bypass freezes the search [RULE1] [RULE25]
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_SEARCH;
      pos_reg <= '0;
      byte_aligned_flag <= 1'b0;
      realign_pulse <= 1'b0;
    end else if (!ctl.comma_align_enable) begin
      state_reg <= ST_SEARCH;
      byte_aligned_flag <= 1'b0;
      realign_pulse <= 1'b0;
    end else begin
      state_reg <= state_next;
      pos_reg <= pos_next;
      byte_aligned_flag <= aligned_next; // [RULE2]
      realign_pulse <= realign_next; // one cycle only [RULE23]
    end
  end
  // auto-slide wait counter
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wait_cnt_reg <= 4'h0;
    end else if (state_reg != ST_WAIT) begin
      wait_cnt_reg <= cfg.auto_slip_wait; // [RULE22]
    end else if (wait_cnt_reg != 4'h0) begin
      wait_cnt_reg <= wait_cnt_reg - 4'h1;
    end
  end
  // re-arm slip only after the request has been low long enough; guards double steps
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gap_cnt_reg <= 6'h00;
      slip_armed_reg <= 1'b1;
    end else if (ctl.bit_slip_request) begin
      gap_cnt_reg <= 6'h00;
      slip_armed_reg <= 1'b0; // one request, one step [RULE6]
    end else if (gap_cnt_reg <= 6'(`RXCA_SLIP_GAP_CYCLES)) begin
      gap_cnt_reg <= gap_cnt_reg + 6'h01;
    end else begin
      slip_armed_reg <= 1'b1; // [RULE7]
    end
  end
  // ******************************************************
  // datapath and comma report
  // ******************************************************
  // history of raw words
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hist1_reg <= '0;
      hist2_reg <= '0;
    end else begin
      hist1_reg <= raw_word;
      hist2_reg <= hist1_reg;
    end
  end
  assign shifted = window[int'(pos_reg) +: W];
  // the realigning comma may be hidden; its whole output word reads as zero [RULE20]
  always_ff @(posedge ref_clk) begin
    if (srst) suppress_reg <= 1'b0;
    else suppress_reg <= realign_next & ctl.comma_align_enable & ~cfg.pass_realign_symbol;
  end
  // output word registered; bypass takes the raw path with less delay [RULE1]
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aligned_word <= '0;
      rx_parallel_word <= '0;
    end else begin
      aligned_word <= shifted;
      if (!ctl.comma_align_enable) rx_parallel_word <= raw_word;
      else if (suppress_reg) rx_parallel_word <= '0;
      else rx_parallel_word <= aligned_word; // trails comma_seen by one clock [RULE5]
    end
  end
  // comma report gated by per-type report bits and comma_align_enable, independent of plus/minus align enables [RULE19] [RULE5]
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      comma_seen <= 1'b0;
    end else if (!ctl.comma_align_enable) begin
      comma_seen <= 1'b0;
    end else if (cfg.double_comma_mode) begin
      comma_seen <= (|double_hit) & cfg.plus_detect_report;
    end else begin
      comma_seen <= ((|plus_hit) & cfg.plus_detect_report) |
                    ((|minus_hit) & cfg.minus_detect_report);
    end
  end
  assign locked_align_position = pos_reg;
endmodule
`default_nettype wire

// file: dv/rxca_aligner_checker.sv
// checker for the receive comma aligner: timing relations seen at its ports
// assumes it is bound to rxca_aligner and watches its ports only
`include "rxca_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rxca_aligner_checker #(
  parameter int NBYTES = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire rxca_pkg::rxca_cfg_t cfg,
  input wire rxca_pkg::rxca_ctl_t ctl,
  input wire logic [NBYTES*10-1:0] raw_word,
  input wire logic [NBYTES*10-1:0] rx_parallel_word,
  input wire logic byte_aligned_flag,
  input wire logic realign_pulse,
  input wire logic comma_seen,
  input wire logic [`RXCA_POS_W-1:0] locked_align_position
);
  import rxca_pkg::*;
  logic quiet;
  logic no_align;
  // ************************************
  // quiet conditions and properties
  // ************************************
  // enables low, no slip, not auto mode: nothing may move the boundary
  assign no_align = !ctl.plus_align_enable && !ctl.minus_align_enable;
  assign quiet = ctl.comma_align_enable && no_align && !ctl.bit_slip_request &&
                 cfg.slip_mode_select != RXCA_SLIP_AUTO;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  reset_quiet_a: assert property (disable iff (1'b0) srst |=>
    !byte_aligned_flag && !realign_pulse && !comma_seen && locked_align_position == 0)
    else $error("status not cleared by reset");
  pulse_single_a: assert property (realign_pulse |=> !realign_pulse)
    else $error("realign pulse longer than one cycle");
  bypass_flag_a: assert property (!ctl.comma_align_enable |=> !byte_aligned_flag)
    else $error("aligned flag high in bypass");
  realign_move_a: assert property (realign_pulse |->
    locked_align_position != $past(locked_align_position)) else $error("pulse without move");
  lane_any_a: assert property (cfg.boundary_granularity == 3'h1 |->
    locked_align_position < 7'h0A) else $error("offset beyond one symbol");
  lane_even_a: assert property (cfg.boundary_granularity == 3'h2 |->
    locked_align_position < 7'h14) else $error("offset beyond two symbols");
  hold_pos_a: assert property (quiet [*3] |-> $stable(locked_align_position))
    else $error("boundary moved while held");
  slip_off_a: assert property ((cfg.slip_mode_select == RXCA_SLIP_OFF && no_align) [*3]
    |-> $stable(locked_align_position)) else $error("slip acted in off mode");
  slip_once_a: assert property ($changed(locked_align_position) && no_align &&
    cfg.slip_mode_select != RXCA_SLIP_AUTO |=> $stable(locked_align_position) [*8])
    else $error("one slip moved the boundary twice");
  report_off_a: assert property (!cfg.plus_detect_report && !cfg.minus_detect_report
    |=> !comma_seen) else $error("comma seen with reporting off");
  flag_needs_a: assert property (!byte_aligned_flag && no_align &&
    cfg.slip_mode_select != RXCA_SLIP_AUTO |=> !byte_aligned_flag)
    else $error("flag rose with align enables low");
  cover property (realign_pulse);
  cover property (comma_seen);
  cover property ($changed(locked_align_position) && !realign_pulse);
endmodule
bind rxca_aligner rxca_aligner_checker #(.NBYTES(NBYTES)) rxca_aligner_checker_i (
  .ref_clk(ref_clk), .srst(srst), .cfg(cfg), .ctl(ctl), .raw_word(raw_word),
  .rx_parallel_word(rx_parallel_word), .byte_aligned_flag(byte_aligned_flag),
  .realign_pulse(realign_pulse), .comma_seen(comma_seen),
  .locked_align_position(locked_align_position));
`default_nettype wire

// file: dv/rxca_user_model.sv
// fabric user logic model: issues bit slip requests on ref_clk
// assumes the bench asks for a slip by a one-cycle go strobe
`timescale 1ns/1ps
`default_nettype none
module rxca_user_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic slip_go,
  input wire logic [7:0] slip_len,
  input wire logic rush,
  output logic slip_req
);
  logic [7:0] low_cnt;
  logic [7:0] hi_cnt;
  // holds the request slip_len cycles; rush breaks the low gap on purpose
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      slip_req <= 1'b0;
      low_cnt <= 8'h00;
      hi_cnt <= 8'h00;
    end else if (slip_req) begin
      slip_req <= (hi_cnt + 8'h01) < slip_len;
      hi_cnt <= hi_cnt + 8'h01;
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= (low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01; // saturate, no wrap
      if (slip_go && (rush || low_cnt > 8'h21)) begin
        slip_req <= 1'b1;
        hi_cnt <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/rxca_aligner_test.sv
// testbench for the receive comma aligner: comma, bypass and slip scenarios
// assumes a four byte word and the checker bound from its own file
`timescale 1ns/1ps
`default_nettype none
module rxca_aligner_test;
  import rxca_pkg::*;
  logic ref_clk, srst, slip_go, rush, slip_req, en, pen, men;
  logic [7:0] slip_len;
  rxca_cfg_t cfg;
  wire rxca_ctl_t ctl;
  logic [39:0] raw_word, rx_parallel_word;
  logic byte_aligned_flag, realign_pulse, comma_seen;
  logic [6:0] locked_align_position;
  logic [9:0] pat, alt;
  int err_total, compares, pulses, seen, found, pos;
  assign ctl = {en, pen, men, slip_req};
  rxca_aligner #(.NBYTES(4)) rxca_aligner_i (.ref_clk(ref_clk), .srst(srst), .cfg(cfg),
    .ctl(ctl), .raw_word(raw_word), .rx_parallel_word(rx_parallel_word),
    .byte_aligned_flag(byte_aligned_flag), .realign_pulse(realign_pulse),
    .comma_seen(comma_seen), .locked_align_position(locked_align_position));
  rxca_user_model rxca_user_model_i (.ref_clk(ref_clk), .srst(srst), .slip_go(slip_go),
    .slip_len(slip_len), .rush(rush), .slip_req(slip_req));
  // ************************************
  // clock, tasks and watchdog
  // ************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // inputs always move 1 ns after the edge so sampling never races
  task tick();
    @(posedge ref_clk);
    #1;
  endtask
  task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      err_total++;
    end
  endtask
  task start(input logic [2:0] gr, input rxca_slip_mode_t md, input logic pr, input logic mr);
    srst = 1'b1;
    cfg.boundary_granularity = gr;
    cfg.slip_mode_select = md;
    cfg.plus_detect_report = pr;
    cfg.minus_detect_report = mr;
    repeat (16) tick();
    srst = 1'b0;
    tick();
  endtask
  // one word in, then idle zeros; latencies are open so six cycles are scanned
  task watch(input logic [39:0] w, input int lane, input logic [9:0] p);
    raw_word = w;
    pulses = 0;
    seen = 0;
    found = 0;
    repeat (6) begin
      tick();
      raw_word = '0;
      pulses += int'(realign_pulse === 1'b1);
      seen |= int'(comma_seen === 1'b1);
      found |= int'(rx_parallel_word[lane +: 10] === p);
    end
  endtask
  task slip(input logic [7:0] l, input logic r);
    slip_len = l;
    rush = r;
    slip_go = 1'b1;
    tick();
    slip_go = 1'b0;
    repeat (int'(l) + 30) tick();
  endtask
  task complete_run();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    complete_run();
  end
  // ************************************
  // scenarios
  // ************************************
  initial begin
    err_total = 0;
    compares = 0;
    {srst, en, pen, men, slip_go, rush, slip_len, raw_word} = {4'hC, 2'h0, 8'h01, 40'h0};
    cfg = '0;
    cfg.minus_pattern = 10'h283;
    cfg.plus_pattern = 10'h17C;
    cfg.comma_match_mask = 10'h3FF;
    cfg.internal_width_select = 1'b1;
    start(3'h1, RXCA_SLIP_OFF, 1'b1, 1'b1);
    chk("status", 40'h0, {byte_aligned_flag, realign_pulse, comma_seen, locked_align_position});
    // minus then plus, granularity one then two; minus reporting is off
    for (int i = 0; i < 4; i++) begin
      start(i[0] ? 3'h2 : 3'h1, RXCA_SLIP_OFF, 1'b1, 1'b0);
      {pen, men} = i[1] ? 2'h2 : 2'h1;
      pos = i[0] ? 13 : 3;
      pat = i[1] ? 10'h17C : 10'h283;
      alt = i[1] ? 10'h283 : 10'h17C;
      watch(40'(alt) << 13, 0, 10'h0);
      chk("disabled type", 40'h0, byte_aligned_flag);
      watch(40'(pat) << 13, 13 - pos, pat);
      chk("pulses", 40'h1, pulses);
      chk("flag", 40'h1, byte_aligned_flag);
      chk("seen", 40'(i[1]), seen);
      chk("position", 40'(pos), locked_align_position);
      chk("hidden comma", 40'h0, found);
      watch(40'(pat) << 13, 13 - pos, pat);
      chk("repeat pulses", 40'h0, pulses);
      chk("comma lane", 40'h1, found);
      {pen, men} = 2'h0;
      watch(40'(pat) << 17, 0, 10'h0);
      chk("held position", 40'(pos), locked_align_position);
    end
    en = 1'b0;
    watch(40'h2A5, 0, 10'h2A5);
    chk("bypass word", 40'h1, found);
    chk("bypass flag", 40'h0, byte_aligned_flag);
    // long request slips once: pcs +1, pma -1 modulo ten, off ignores it
    for (int m = 0; m < 3; m++) begin
      start(3'h1, m == 0 ? RXCA_SLIP_PCS : (m == 1 ? RXCA_SLIP_PMA : RXCA_SLIP_OFF), 1'b0, 1'b0);
      {en, pen, men} = 3'h4;
      repeat (40) tick();
      slip(8'h14, 1'b0);
      chk("slip position", m == 0 ? 40'h1 : (m == 1 ? 40'h9 : 40'h0), locked_align_position);
    end
    start(3'h1, RXCA_SLIP_PCS, 1'b0, 1'b0);
    repeat (40) tick();
    slip(8'h01, 1'b0);
    slip(8'h01, 1'b1);
    chk("early slip", 40'h1, locked_align_position);
    repeat (40) tick();
    slip(8'h01, 1'b0);
    chk("second slip", 40'h2, locked_align_position);
    // double mode: plus alone is not a match, plus then minus is
    cfg.double_comma_mode = 1'b1;
    start(3'h1, RXCA_SLIP_OFF, 1'b1, 1'b1);
    {pen, men} = 2'h3;
    watch(40'h17C << 13, 0, 10'h0);
    chk("lone plus", 40'h0, byte_aligned_flag);
    watch((40'h283 << 23) | (40'h17C << 13), 10, 10'h17C);
    chk("double pulses", 40'h1, pulses);
    chk("double seen", 40'h1, seen);
    chk("double position", 40'h3, locked_align_position);
    chk("double hidden", 40'h0, found);
    // auto mode slides on its own while no comma is found
    cfg.double_comma_mode = 1'b0;
    start(3'h1, RXCA_SLIP_AUTO, 1'b0, 1'b0);
    {pen, men} = 2'h0;
    repeat (5) tick();
    chk("auto slide", 40'h1, 40'(locked_align_position != 7'h00));
    complete_run();
  end
endmodule
`default_nettype wire
